// ---- design/dacr_pkg.sv ----
// Constants, register map and carrier types of the converter configuration bank
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none
package dacr_pkg;

	localparam int REG_NUM = 15;
	localparam int ADDR_W = 13;

	localparam logic [ADDR_W-1:0] ADDR_CHSEL = 13'h0003;
	localparam logic [ADDR_W-1:0] ADDR_PWR = 13'h0005;
	localparam logic [ADDR_W-1:0] ADDR_CHK0 = 13'h084C;
	localparam logic [ADDR_W-1:0] ADDR_CHK1 = 13'h084D;

	// Entry order: channel select, power A and B, six link words, two lane ids, lane and converter controls
	localparam int IDX_CHSEL = 0;
	localparam int IDX_PWR_A = 1;
	localparam int IDX_PWR_B = 2;
	localparam int IDX_LANE0 = 11;
	localparam int IDX_LANE1 = 12;
	localparam int IDX_CONV_A = 13;
	localparam int IDX_CONV_B = 14;

	localparam logic [ADDR_W-1:0] REG_ADDR [REG_NUM] = '{13'h0003, 13'h0005, 13'h0005, 13'h0824, 13'h0825,
		13'h0826, 13'h0827, 13'h0828, 13'h0829, 13'h082C, 13'h082D, 13'h0870, 13'h0871, 13'h0890, 13'h0891};
	localparam logic [7:0] REG_RST [REG_NUM] = '{8'hFF, 8'h00, 8'h00, 8'h08, 8'h00,
		8'h42, 8'h0F, 8'h00, 8'h00, 8'h1B, 8'h1C, 8'h01, 8'h00, 8'h01, 8'h00};
	localparam logic [7:0] REG_WMASK [REG_NUM] = '{8'h03, 8'h03, 8'h03, 8'h1F, 8'h01,
		8'h4F, 8'h1F, 8'h01, 8'h83, 8'h1F, 8'h1F, 8'h77, 8'h77, 8'h31, 8'h31};
	localparam logic [REG_NUM-1:0] REG_COND = 15'b000_0111_1011_1000;

	localparam int SOFT_RST_BIT = 7;
	localparam logic [1:0] PWR_FULL_DOWN = 2'b01;
	localparam logic [1:0] PWR_SLEEP = 2'b10;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [3:0] INSTR_LAST = 4'hF;
	localparam logic [3:0] BYTE_LAST = 4'h7;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_INSTR = 2'b01,
		ST_DATA = 2'b10
	} dacr_state_type;

	typedef struct packed
	{
		logic [1:0] power_state_code;
		logic full_power_down;
		logic sleep;
		logic [1:0] conv_mode;
		logic converter_power_off;
	} dacr_conv_type;

	typedef struct packed
	{
		logic scr_in_mode;
		logic [1:0] lane_mode;
		logic lane_pol;
		logic lane_clk_pos_edge;
		logic lane_power_off;
		logic [4:0] lane_identifier;
	} dacr_lane_type;

	typedef struct packed
	{
		logic [4:0] frames_per_multiframe;
		logic converter_count;
		logic control_bits;
		logic [3:0] resolution;
		logic [4:0] sample_word_width;
		logic samples_per_frame;
		logic high_density;
		logic [1:0] control_words;
	} dacr_link_type;

endpackage
`default_nettype wire

// ---- design/dacr_top.sv ----
// Serial configuration slave and register bank of the dual converter
`timescale 1ns/1ps
`default_nettype none
module dacr_top
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n_o,
	input wire logic link_wr_allow_i,
	input wire logic [7:0] lane0_checksum_i,
	input wire logic [7:0] lane1_checksum_i,
	output var dacr_pkg::dacr_conv_type conv_a_o,
	output var dacr_pkg::dacr_conv_type conv_b_o,
	output var dacr_pkg::dacr_lane_type lane0_o,
	output var dacr_pkg::dacr_lane_type lane1_o,
	output var dacr_pkg::dacr_link_type link_o,
	output logic digital_soft_reset_o
);
	import dacr_pkg::*;

	//--------------------------------------------------------------------------
	// Reset release and pin synchronisers
	//--------------------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_n_ff;
	logic [2:0] pin_meta_ff;
	logic [2:0] pin_ff;
	logic sclk_last_ff;

	always_ff @(posedge clk_sys_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			pin_meta_ff <= 3'h4;
			pin_ff <= 3'h4;
			sclk_last_ff <= 1'b0;
		end
		else
		begin
			pin_meta_ff <= {cs_n_i, sclk_i, sdio_i};
			pin_ff <= pin_meta_ff;
			sclk_last_ff <= pin_ff[1];
		end
	end

	logic cs_n_s;
	logic sdi_s;
	logic sclk_rise;
	logic sclk_fall;
	assign cs_n_s = pin_ff[2];
	assign sdi_s = pin_ff[0];
	assign sclk_rise = pin_ff[1] & ~sclk_last_ff;
	assign sclk_fall = ~pin_ff[1] & sclk_last_ff;

	//--------------------------------------------------------------------------
	// Register storage and read decode
	//--------------------------------------------------------------------------
	logic [7:0] reg_ff [REG_NUM];
	logic soft_rst_ff;
	logic nxt_soft_rst;
	logic sel_a;
	logic sel_b;
	assign sel_a = reg_ff[IDX_CHSEL][0];
	assign sel_b = reg_ff[IDX_CHSEL][1];

	function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] a);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < REG_NUM; i++)
		begin
			if (a == REG_ADDR[i] && i != IDX_PWR_A && i != IDX_PWR_B)
			begin
				d = reg_ff[i];
			end
		end
		if (a == ADDR_PWR)
		begin
			d = (sel_a || !sel_b) ? reg_ff[IDX_PWR_A] : reg_ff[IDX_PWR_B];
			d[SOFT_RST_BIT] = soft_rst_ff;
		end
		if (a == ADDR_CHK0)
		begin
			d = lane0_checksum_i;
		end
		if (a == ADDR_CHK1)
		begin
			d = lane1_checksum_i;
		end
		return d;
	endfunction

	//--------------------------------------------------------------------------
	// Serial transfer engine
	//--------------------------------------------------------------------------
	dacr_state_type state_ff;
	dacr_state_type nxt_state;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [15:0] sh_ff;
	logic [15:0] nxt_sh;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [ADDR_W-1:0] addr_ff;
	logic [ADDR_W-1:0] nxt_addr;
	logic rnw_ff;
	logic nxt_rnw;
	logic sdo_ff;
	logic nxt_sdo;
	logic wr_stb;
	logic [7:0] wr_data;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_addr = addr_ff;
		nxt_rnw = rnw_ff;
		nxt_sdo = sdo_ff;
		wr_stb = 1'b0;
		wr_data = {sh_ff[6:0], sdi_s};
		case (state_ff)
			ST_IDLE:
			begin
				nxt_cnt = BIT_CNT_RST;
				if (!cs_n_s)
				begin
					nxt_state = ST_INSTR;
				end
			end
			ST_INSTR:
			begin
				if (sclk_rise)
				begin
					nxt_sh = {sh_ff[14:0], sdi_s};
					nxt_cnt = cnt_ff + 4'h1;
					if (cnt_ff == INSTR_LAST)
					begin
						nxt_rnw = sh_ff[14];
						nxt_addr = {sh_ff[11:0], sdi_s};
						nxt_tx = rd_byte({sh_ff[11:0], sdi_s});
						nxt_cnt = BIT_CNT_RST;
						nxt_state = ST_DATA;
					end
				end
			end
			ST_DATA:
			begin
				if (sclk_rise)
				begin
					nxt_sh = {sh_ff[14:0], sdi_s};
					nxt_cnt = cnt_ff + 4'h1;
					if (cnt_ff == BYTE_LAST)
					begin
						wr_stb = !rnw_ff;
						nxt_addr = addr_ff + 13'h0001;
						nxt_tx = rd_byte(addr_ff + 13'h0001);
						nxt_cnt = BIT_CNT_RST;
					end
				end
				else if (sclk_fall && rnw_ff)
				begin
					nxt_sdo = tx_ff[7];
					nxt_tx = {tx_ff[6:0], 1'b0};
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (cs_n_s)
		begin
			nxt_state = ST_IDLE;
			nxt_sdo = 1'b0;
		end
		nxt_soft_rst = wr_stb && addr_ff == ADDR_PWR && wr_data[SOFT_RST_BIT];
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= BIT_CNT_RST;
			sh_ff <= 16'h0000;
			tx_ff <= 8'h00;
			addr_ff <= 13'h0000;
			rnw_ff <= 1'b0;
			sdo_ff <= 1'b0;
			soft_rst_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			addr_ff <= nxt_addr;
			rnw_ff <= nxt_rnw;
			sdo_ff <= nxt_sdo;
			soft_rst_ff <= nxt_soft_rst;
		end
	end

	assign sdio_o = sdo_ff;
	assign sdio_oe_n_o = !(state_ff == ST_DATA && rnw_ff && !cs_n_s);

	//--------------------------------------------------------------------------
	// Register writes
	//--------------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < REG_NUM; gi++)
		begin : g_reg
			logic hit;
			logic [7:0] nxt_reg;
			always_comb
			begin
				hit = wr_stb && addr_ff == REG_ADDR[gi];
				if (REG_COND[gi] && !link_wr_allow_i)
				begin
					hit = 1'b0;
				end
				if (gi == IDX_PWR_A && !sel_a)
				begin
					hit = 1'b0;
				end
				if (gi == IDX_PWR_B && !sel_b)
				begin
					hit = 1'b0;
				end
				nxt_reg = reg_ff[gi];
				if (soft_rst_ff)
				begin
					nxt_reg = REG_RST[gi];
				end
				else if (hit)
				begin
					nxt_reg = (wr_data & REG_WMASK[gi]) | (reg_ff[gi] & ~REG_WMASK[gi]);
				end
			end
			always_ff @(posedge clk_sys_i or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
				begin
					reg_ff[gi] <= REG_RST[gi];
				end
				else
				begin
					reg_ff[gi] <= nxt_reg;
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	always_comb
	begin
		conv_a_o.power_state_code = reg_ff[IDX_PWR_A][1:0];
		conv_a_o.full_power_down = reg_ff[IDX_PWR_A][1:0] == PWR_FULL_DOWN;
		conv_a_o.sleep = reg_ff[IDX_PWR_A][1:0] == PWR_SLEEP;
		conv_a_o.conv_mode = reg_ff[IDX_CONV_A][5:4];
		conv_a_o.converter_power_off = reg_ff[IDX_CONV_A][0];
		conv_b_o.power_state_code = reg_ff[IDX_PWR_B][1:0];
		conv_b_o.full_power_down = reg_ff[IDX_PWR_B][1:0] == PWR_FULL_DOWN;
		conv_b_o.sleep = reg_ff[IDX_PWR_B][1:0] == PWR_SLEEP;
		conv_b_o.conv_mode = reg_ff[IDX_CONV_B][5:4];
		conv_b_o.converter_power_off = reg_ff[IDX_CONV_B][0];
		lane0_o = {reg_ff[IDX_LANE0][6:4], reg_ff[IDX_LANE0][2:0], reg_ff[9][4:0]};
		lane1_o = {reg_ff[IDX_LANE1][6:4], reg_ff[IDX_LANE1][2:0], reg_ff[10][4:0]};
		link_o = {reg_ff[3][4:0], reg_ff[4][0], reg_ff[5][6], reg_ff[5][3:0], reg_ff[6][4:0], reg_ff[7][0],
			reg_ff[8][7], reg_ff[8][1:0]};
	end

	assign digital_soft_reset_o = soft_rst_ff;

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_ff);

	a_chsel_upper_ones: assert property (reg_ff[IDX_CHSEL][7:2] == 6'h3F)
		else $error("channel select upper bits not all ones");
	a_pwr_b_gated: assert property (wr_stb && addr_ff == ADDR_PWR && !sel_b && !soft_rst_ff
		|=> $stable(reg_ff[IDX_PWR_B]))
		else $error("converter B power changed while deselected");
	a_pwr_a_gated: assert property (wr_stb && addr_ff == ADDR_PWR && !sel_a && !soft_rst_ff
		|=> $stable(reg_ff[IDX_PWR_A]))
		else $error("converter A power changed while deselected");
	a_pwr_both_take: assert property (wr_stb && addr_ff == ADDR_PWR && sel_a && sel_b && !soft_rst_ff
		|=> reg_ff[IDX_PWR_A][1:0] == $past(wr_data[1:0]) && reg_ff[IDX_PWR_B][1:0] == $past(wr_data[1:0]))
		else $error("write did not reach both converters");
	a_soft_rst_seq: assert property (wr_stb && addr_ff == ADDR_PWR && wr_data[SOFT_RST_BIT]
		|=> soft_rst_ff ##1 (!soft_rst_ff && reg_ff[IDX_CHSEL] == 8'hFF && reg_ff[IDX_CONV_A] == 8'h01))
		else $error("soft reset did not restore defaults");
	a_srst_self_clear: assert property (soft_rst_ff |=> !soft_rst_ff)
		else $error("soft reset bit stuck");
	a_power_decode: assert property (conv_a_o.full_power_down == (reg_ff[IDX_PWR_A][1:0] == 2'b01)
		&& conv_a_o.sleep == (reg_ff[IDX_PWR_A][1:0] == 2'b10))
		else $error("power code decode wrong");
	a_cond_refused: assert property (wr_stb && addr_ff == REG_ADDR[3] && !link_wr_allow_i && !soft_rst_ff
		|=> $stable(reg_ff[3]))
		else $error("conditional register written without access");
	a_sdo_quiet: assert property (cs_n_s |-> sdio_oe_n_o)
		else $error("data pin driven outside a frame");

	c_write_pwr: cover property (wr_stb && addr_ff == ADDR_PWR);
	c_read_frame: cover property (state_ff == ST_DATA && rnw_ff && sclk_fall);
	c_soft_rst: cover property (soft_rst_ff);
	c_pwr_b_only: cover property (wr_stb && addr_ff == ADDR_PWR && sel_b && !sel_a);

endmodule
`default_nettype wire

// ---- bench/dacr_host.sv ----
// Host serial master model driving configuration frames
`timescale 1ns/1ps
`default_nettype none
module dacr_host
(
	input wire logic clk_i,
	input wire logic sdio_i,
	output logic sclk_o,
	output logic cs_n_o,
	output logic sdio_o
);
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdio_o = 1'b0;
	end
	task automatic half;
		repeat (8) @(posedge clk_i);
		#1;
	endtask
	// Instruction then n bytes; sclk stands low between frames
	task automatic xfer(input logic rd, input logic [12:0] a, input int n, input logic [31:0] wd,
		output logic [31:0] q);
		logic [15:0] ins;
		ins = {rd, 2'b11, a};
		q = '0;
		cs_n_o = 1'b0;
		half;
		for (int i = 0; i < 16 + 8 * n; i++)
		begin
			if (i < 16)
				sdio_o = ins[15 - i];
			else if (!rd)
				sdio_o = wd[47 - i];
			else
				sdio_o = ~sdio_o;
			half;
			sclk_o = 1'b1;
			if (i >= 16)
				q = {q[30:0], sdio_i};
			half;
			sclk_o = 1'b0;
		end
		half;
		cs_n_o = 1'b1;
		sdio_o = ~sdio_o;
		half;
	endtask
endmodule
`default_nettype wire

// ---- bench/test_dacr_top.sv ----
// Register-level testbench of the converter configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_dacr_top;
	import dacr_pkg::*;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic allow = 1'b0;
	logic [7:0] ck0 = 8'hA5;
	logic [7:0] ck1 = 8'h5A;
	wire logic sclk;
	wire logic cs_n;
	wire logic host_d;
	logic dev_d;
	logic dev_oe_n;
	logic srst;
	dacr_conv_type conv_a;
	dacr_conv_type conv_b;
	dacr_lane_type lane0;
	dacr_lane_type lane1;
	dacr_link_type link;
	wire logic sdio_w = !dev_oe_n ? dev_d : host_d;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int n_srst = 0;
	logic [31:0] r;
	logic [12:0] ra [13] = '{13'h0003, 13'h0824, 13'h0825, 13'h0826, 13'h0827, 13'h0828, 13'h0829,
		13'h082C, 13'h082D, 13'h0870, 13'h0871, 13'h0890, 13'h0891};
	logic [7:0] rs [13] = '{8'hFF, 8'h08, 8'h00, 8'h42, 8'h0F, 8'h00, 8'h00, 8'h1B, 8'h1C, 8'h01, 8'h00,
		8'h01, 8'h00};
	logic [7:0] wm [13] = '{8'hFF, 8'h1F, 8'h01, 8'h4F, 8'h1F, 8'h01, 8'h83, 8'h1F, 8'h1F, 8'h77, 8'h77,
		8'h31, 8'h31};
	logic [3:0] pwr_exp [4] = '{4'b0000, 4'b1010, 4'b0101, 4'b0000};
	dacr_top dacr_top_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n),
		.sdio_i(sdio_w), .sdio_o(dev_d), .sdio_oe_n_o(dev_oe_n), .link_wr_allow_i(allow),
		.lane0_checksum_i(ck0), .lane1_checksum_i(ck1), .conv_a_o(conv_a), .conv_b_o(conv_b),
		.lane0_o(lane0), .lane1_o(lane1), .link_o(link), .digital_soft_reset_o(srst));
	dacr_host dacr_host_i (.clk_i(clk_sys_i), .sdio_i(sdio_w), .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(host_d));
	initial
	forever
		#5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (srst === 1'b1)
			n_srst++;
		if (cyc == 60000)
		begin
			n_mismatch++;
			close_out;
		end
	end
	task close_out;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [12:0] a, input logic [7:0] d);
		dacr_host_i.xfer(1'b0, a, 1, {d, 24'h0}, r);
	endtask
	task chk_rd(input logic [12:0] a, input logic [7:0] e);
		dacr_host_i.xfer(1'b1, a, 1, 32'h0, r);
		`CHK(r[7:0], e)
	endtask
	//--------------------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		#1 nrst_i = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		#1;
		for (int i = 0; i < 13; i++)
			chk_rd(ra[i], rs[i]);
		chk_rd(13'h0005, 8'h00);
		chk_rd(13'h084C, 8'hA5);
		chk_rd(13'h0004, 8'h00);
		dacr_host_i.xfer(1'b1, 13'h0890, 2, 32'h0, r);
		`CHK(r[15:0], 16'h0100)
		wr(13'h0824, 8'h00);
		wr(13'h0827, 8'h00);
		wr(13'h0829, 8'hFF);
		chk_rd(13'h0829, 8'h00);
		chk_rd(13'h0824, 8'h08);
		chk_rd(13'h0827, 8'h00);
		allow = 1'b1;
		for (int i = 0; i < 13; i++)
		begin
			wr(ra[i], 8'hFF);
			chk_rd(ra[i], wm[i]);
		end
		`CHK(link.frames_per_multiframe, 5'h1F)
		`CHK(link, 20'hFFFFF)
		`CHK(lane0, 11'h7FF)
		`CHK(lane1, 11'h7FF)
		wr(13'h084D, 8'h00);
		chk_rd(13'h084D, 8'h5A);
		wr(13'h0003, 8'h01);
		wr(13'h0005, 8'h01);
		`CHK(conv_a.full_power_down, 1'b1)
		`CHK(conv_b.power_state_code, 2'b00)
		wr(13'h0003, 8'h02);
		wr(13'h0005, 8'h02);
		`CHK(conv_b.sleep, 1'b1)
		`CHK(conv_a.power_state_code, 2'b01)
		chk_rd(13'h0005, 8'h02);
		wr(13'h0003, 8'h03);
		for (int c = 0; c < 4; c++)
		begin
			wr(13'h0005, c[7:0]);
			`CHK({conv_a.full_power_down, conv_a.sleep, conv_b.full_power_down, conv_b.sleep}, pwr_exp[c])
		end
		`CHK(n_srst, 0)
		wr(13'h0005, 8'h80);
		`CHK(n_srst, 1)
		`CHK(conv_a.power_state_code, 2'b00)
		chk_rd(13'h0005, 8'h00);
		chk_rd(13'h0003, 8'hFF);
		chk_rd(13'h0824, 8'h08);
		`CHK(link, 20'h424F0)
		`CHK(lane0, 11'h03B)
		`CHK(lane1, 11'h01C)
		close_out;
	end
endmodule
`undef CHK
`default_nettype wire
